// ---- hdl/readout_pkg.sv ----
/*
  Constants for the serial status readback block: selection codes,
  word layouts, field positions and reset values.
  Assumes a 16-bit serial word and five power channels.
*/
`default_nettype none

package readout_pkg;
  // Channel count and widths
  localparam int NUM_CH = 5;
  localparam int NUM_IN = 4;
  localparam int WORD_W = 16;
  localparam int SEL_W = 4;
  // Selection codes
  localparam logic [3:0] SEL_QUICK_ALIAS = 4'h0;
  localparam logic [3:0] SEL_QUICK = 4'h1;
  localparam logic [3:0] SEL_CH_FIRST = 4'h2;
  localparam logic [3:0] SEL_CH_LAST = 4'h6;
  localparam logic [3:0] SEL_DEVICE = 4'h7;
  localparam logic [3:0] SEL_IO = 4'h8;
  localparam logic [3:0] SEL_ID = 4'h9;
  // Overcurrent cause codes
  localparam logic [2:0] OC_NONE = 3'h0;
  localparam logic [2:0] OC_INRUSH_FIRST = 3'h1;
  localparam logic [2:0] OC_INRUSH_SECOND = 3'h2;
  localparam logic [2:0] OC_INRUSH_THIRD = 3'h3;
  localparam logic [2:0] OC_LOW_THRESHOLD = 3'h4;
  localparam logic [2:0] OC_INRUSH_OFF = 3'h5;
  localparam logic [2:0] OC_SEVERE_SHORT = 3'h6;
  localparam logic [2:0] OC_UNUSED = 3'h7;
  // Part code, value arbitrary
  localparam logic [7:0] PART_CODE = 8'h5a;
  localparam logic [7:0] PART_CODE_UV = 8'h00;
  // Reset values
  localparam logic [6:0] CH_FAULT_RST = 7'h00;
  localparam logic [3:0] SEL_RST = 4'h1;
  // Bit positions
  localparam int BIT_FM = 11;
  localparam int BIT_DSF = 10;
  localparam int BIT_OVERLOAD_SUMMARY_FLAG = 9;
  localparam int BIT_OLF = 8;
  localparam int BIT_TOGGLE = 9;
endpackage : readout_pkg

`default_nettype wire

// ---- hdl/spi_fault_status_readout.sv ----
/*
  Status word readback logic of a five-channel high-side switch.
  Assumes a serial front end on the same clock that delivers the written
  selection with a one-cycle strobe and marks each completed read with a
  one-cycle strobe; analog inputs are already synchronised and deglitched.
  Hazards: a fault present in the clearing cycle sets its flag again,
  and a selection write in the read cycle wins over the revert.
  Summary flags are derived, never stored, so they fall with their sources.
  Limp, control, toggle and output-level fields are passed through unlatched.
*/
// Summary of operation
// - Four-bit field selects returned status word
// - Non-persistent selection reverts to overview after read
// - Persistent selection holds until reprogrammed
// - Code zero returns overview word too
// - Bit 11 shows fail mode always
// - Summary flags clear after underlying faults read
// - Device summary ORs six device flags
// - Overload summary ORs overcurrent and shutdown
// - Registers-cleared flag set on register reset
// - Channel quick flag ORs channel faults
// - Channel word layout for codes two-six
// - Overcurrent cause coding, newest fault wins
// - Device word layout for code seven
// - Limp bit real time, unlatched
// - I/O word real time, code eight
// - Toggle indicator ORs four toggles
// - Output state valid without undervoltage
// - Part code zero during undervoltage
// - Channel diagnosis released only by read
`default_nettype none

module spi_fault_status_readout (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sel_write_i,
  input wire logic [3:0] readback_select_field_i,
  input wire logic readback_select_persist_i,
  input wire logic read_done_i,
  input wire logic regs_reset_i,
  input wire logic fail_mode_indicator_i,
  input wire logic [4:0] overtemp_shutdown_i,
  input wire logic [4:0] overtemp_warning_i,
  input wire logic [4:0] oc_event_i,
  input wire logic [14:0] overcurrent_cause_i,
  input wire logic [4:0] open_load_on_state_i,
  input wire logic [4:0] open_load_off_state_i,
  input wire logic test_mode_i,
  input wire logic overvoltage_i,
  input wire logic undervoltage_i,
  input wire logic serial_fail_i,
  input wire logic charge_pump_i,
  input wire logic clock_fail_i,
  input wire logic limp_input_state_i,
  input wire logic [3:0] control_input_state_i,
  input wire logic [3:0] toggle_signal_i,
  input wire logic [4:0] output_level_state_i,
  output logic [15:0] status_word_o,
  output logic [3:0] active_select_o
);

  ////////////////////////////////////////////////////////////////////////
  // State

  // Latched per-channel fault content
  typedef struct packed {
    logic ots;
    logic otw;
    logic [2:0] oc;
    logic olon;
    logic oloff;
  } ch_type;

  // Whole module state
  // Output word is kept here so the port comes from a flip-flop
  typedef struct packed {
    ch_type [4:0] ch;
    logic [3:0] sel;
    logic persist;
    logic test_mode_flag;
    logic ovf;
    logic undervoltage_flag;
    logic serial_fail_flag;
    logic charge_pump_fault;
    logic clock_fail_flag;
    logic regs_cleared_flag;
    logic [15:0] word;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  // Combined flags
  logic [4:0] quick_flag;
  logic device_summary_flag;
  logic overload_summary_flag;
  logic open_load_summary_flag;
  logic [15:0] word_next;

  ////////////////////////////////////////////////////////////////////////
  // Summary flags from latched content
  // Pure OR trees; clearing all sources clears the flag

  always_comb begin
    overload_summary_flag = 1'b0;
    open_load_summary_flag = 1'b0;
    for (int c = 0; c < readout_pkg::NUM_CH; c++) begin
      quick_flag[c] = (|st_ff.ch[c].oc) | st_ff.ch[c].otw | st_ff.ch[c].ots |
                      st_ff.ch[c].olon | st_ff.ch[c].oloff;
      overload_summary_flag = overload_summary_flag | (|st_ff.ch[c].oc) | st_ff.ch[c].ots;
      open_load_summary_flag = open_load_summary_flag | st_ff.ch[c].olon | st_ff.ch[c].oloff;
    end
    device_summary_flag = st_ff.regs_cleared_flag | st_ff.undervoltage_flag | st_ff.ovf | st_ff.charge_pump_fault | st_ff.clock_fail_flag | st_ff.test_mode_flag;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output word mux
  // Registered next cycle into the output word

  always_comb begin
    int idx;
    idx = 0;
    word_next = '0;
    case (st_ff.sel)
      readout_pkg::SEL_QUICK_ALIAS, readout_pkg::SEL_QUICK: begin
        word_next[15:12] = readout_pkg::SEL_QUICK;
        word_next[7] = st_ff.charge_pump_fault;
        word_next[6] = st_ff.regs_cleared_flag;
        word_next[5] = st_ff.clock_fail_flag;
        word_next[4:0] = quick_flag;
      end
      // device word layout
      // Bits seven to five reserved, left zero
      readout_pkg::SEL_DEVICE: begin
        word_next[15:12] = readout_pkg::SEL_DEVICE;
        word_next[4] = st_ff.test_mode_flag;
        word_next[3] = st_ff.ovf;
        word_next[2] = st_ff.undervoltage_flag;
        word_next[1] = st_ff.serial_fail_flag;
        word_next[0] = limp_input_state_i;
      end
      readout_pkg::SEL_IO: begin
        word_next[15:12] = readout_pkg::SEL_IO;
        word_next[readout_pkg::BIT_TOGGLE] = |toggle_signal_i;
        word_next[8:5] = control_input_state_i;
        // comparator states, meaningless under undervoltage
        // Controller must check the undervoltage flag first
        word_next[4:0] = output_level_state_i;
      end
      // part code gated by undervoltage
      // Zero part code while the latched undervoltage flag stands
      readout_pkg::SEL_ID: begin
        word_next[15:12] = readout_pkg::SEL_ID;
        word_next[7:0] = st_ff.undervoltage_flag ? readout_pkg::PART_CODE_UV : readout_pkg::PART_CODE;
      end
      default: begin
        // Channel codes land here; codes above nine give only the fail bit
        // channel word layout
        if (st_ff.sel >= readout_pkg::SEL_CH_FIRST && st_ff.sel <= readout_pkg::SEL_CH_LAST) begin
          idx = int'(st_ff.sel - readout_pkg::SEL_CH_FIRST);
          word_next[15:12] = st_ff.sel;
          word_next[6:0] = st_ff.ch[idx];
        end
      end
    endcase
    // summary flags in words up to seven
    // Overview, channel and device words carry the summaries
    if (st_ff.sel <= readout_pkg::SEL_DEVICE) begin
      word_next[readout_pkg::BIT_DSF] = device_summary_flag;
      word_next[readout_pkg::BIT_OVERLOAD_SUMMARY_FLAG] = overload_summary_flag;
      word_next[readout_pkg::BIT_OLF] = open_load_summary_flag;
    end
    // fail mode in every word
    // Applied last so no branch can lose it
    word_next[readout_pkg::BIT_FM] = fail_mode_indicator_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    // Order matters: clears first, then sets, then the selection write,
    // so a fault in the clearing cycle wins over the clear and a write
    // in the read cycle wins over the revert to the overview word
    nxt_st = st_ff;
    nxt_st.word = word_next;
    // Clearing read of selected latched words
    if (read_done_i) begin
      // channel release on its read
      // Only the word actually shifted out is released
      for (int c = 0; c < readout_pkg::NUM_CH; c++) begin
        if (st_ff.sel == readout_pkg::SEL_CH_FIRST + 4'(c)) begin
          nxt_st.ch[c] = readout_pkg::CH_FAULT_RST;
        end
      end
      // Device word read releases its own latched flags
      if (st_ff.sel == readout_pkg::SEL_DEVICE) begin
        nxt_st.test_mode_flag = 1'b0;
        nxt_st.ovf = 1'b0;
        nxt_st.undervoltage_flag = 1'b0;
        nxt_st.serial_fail_flag = 1'b0;
      end
      // Overview read clears its own device flags
      if (st_ff.sel <= readout_pkg::SEL_QUICK) begin
        nxt_st.charge_pump_fault = 1'b0;
        nxt_st.clock_fail_flag = 1'b0;
        nxt_st.regs_cleared_flag = 1'b0;
      end
      if (!st_ff.persist) begin
        nxt_st.sel = readout_pkg::SEL_QUICK;
      end
    end
    for (int c = 0; c < readout_pkg::NUM_CH; c++) begin
      // Shutdown latch
      if (overtemp_shutdown_i[c]) begin
        nxt_st.ch[c].ots = 1'b1;
      end
      // Warning latch
      if (overtemp_warning_i[c]) begin
        nxt_st.ch[c].otw = 1'b1;
      end
      // Open load in on state latch
      if (open_load_on_state_i[c]) begin
        nxt_st.ch[c].olon = 1'b1;
      end
      // Open load in off state latch
      if (open_load_off_state_i[c]) begin
        nxt_st.ch[c].oloff = 1'b1;
      end
      // Code seven carries no cause, so the older code stays
      // newest cause overwrites
      if (oc_event_i[c] && overcurrent_cause_i[3*c +: 3] != readout_pkg::OC_UNUSED) begin
        nxt_st.ch[c].oc = overcurrent_cause_i[3*c +: 3];
      end
    end
    // Test mode latch
    if (test_mode_i) begin
      nxt_st.test_mode_flag = 1'b1;
    end
    // Overvoltage latch
    if (overvoltage_i) begin
      nxt_st.ovf = 1'b1;
    end
    // Undervoltage latch
    if (undervoltage_i) begin
      nxt_st.undervoltage_flag = 1'b1;
    end
    // Serial interface failure latch
    if (serial_fail_i) begin
      nxt_st.serial_fail_flag = 1'b1;
    end
    // Charge pump fault latch
    if (charge_pump_i) begin
      nxt_st.charge_pump_fault = 1'b1;
    end
    // Clock failure latch
    if (clock_fail_i) begin
      nxt_st.clock_fail_flag = 1'b1;
    end
    if (regs_reset_i) begin
      nxt_st.regs_cleared_flag = 1'b1;
    end
    // Write in the read cycle wins over the revert
    // new programming takes over
    if (sel_write_i) begin
      nxt_st.sel = readback_select_field_i;
      nxt_st.persist = readback_select_persist_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  // Reset selects the overview word and raises the regs-cleared flag

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.sel <= readout_pkg::SEL_RST;
      st_ff.regs_cleared_flag <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Ports straight from registered state
  assign status_word_o = st_ff.word;
  assign active_select_o = st_ff.sel;

endmodule : spi_fault_status_readout

`default_nettype wire

// ---- tb/readout_properties.sv ----
/* Checker for the status readback block.
   Assumes only the block's own ports on one clock. */
`default_nettype none
module readout_properties (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sel_write_i,
  input wire logic [3:0] readback_select_field_i,
  input wire logic readback_select_persist_i,
  input wire logic read_done_i,
  input wire logic fail_mode_indicator_i,
  input wire logic [4:0] overtemp_shutdown_i,
  input wire logic [4:0] overtemp_warning_i,
  input wire logic [3:0] control_input_state_i,
  input wire logic [3:0] toggle_signal_i,
  input wire logic [15:0] status_word_o,
  input wire logic [3:0] active_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Selection, idle gap, then one completed read
  sequence s_pick(p);
    sel_write_i && readback_select_persist_i == p ##1 (!sel_write_i && !read_done_i) [*4]
      ##1 read_done_i && !sel_write_i;
  endsequence
  chk_select_taken: assert property (
    sel_write_i |=> active_select_o == $past(readback_select_field_i)) else $error("select");
  chk_oneshot_revert: assert property (
    s_pick(1'b0) |=> active_select_o == 4'h1) else $error("revert");
  chk_persist_hold: assert property (
    s_pick(1'b1) |=> active_select_o == $past(readback_select_field_i, 6)) else $error("hold");
  chk_address_nibble: assert property (
    !$past(rst_i) && $past(active_select_o) <= 4'h9 |-> status_word_o[15:12] ==
    ($past(active_select_o) == 4'h0 ? 4'h1 : $past(active_select_o))) else $error("nibble");
  chk_fail_bit: assert property (
    fail_mode_indicator_i [*3] |-> status_word_o[11]) else $error("fail bit");
  chk_io_realtime: assert property (
    $past(active_select_o) == 4'h8 && !$past(rst_i) |-> status_word_o[10:5] ==
    {1'b0, |$past(toggle_signal_i), $past(control_input_state_i)}) else $error("io");
  chk_quick_latch: assert property (
    $past(overtemp_warning_i, 2) != 5'h00 && $past(active_select_o) == 4'h1
    && !$past(read_done_i) && !$past(rst_i) && !$past(rst_i, 2) |-> (status_word_o[4:0]
    & $past(overtemp_warning_i, 2)) == $past(overtemp_warning_i, 2)) else $error("quick");
  chk_overload_flag: assert property (
    $past(overtemp_shutdown_i, 2) != 5'h00 && $past(active_select_o) <= 4'h7
    && !$past(read_done_i) && !$past(rst_i) && !$past(rst_i, 2) |-> status_word_o[9])
    else $error("overload");
endmodule : readout_properties
bind spi_fault_status_readout readout_properties u_readout_properties (.clk_sys_i, .rst_i,
  .sel_write_i, .readback_select_field_i, .readback_select_persist_i, .read_done_i,
  .fail_mode_indicator_i, .overtemp_shutdown_i, .overtemp_warning_i, .control_input_state_i,
  .toggle_signal_i, .status_word_o, .active_select_o);
`default_nettype wire

// ---- tb/mcu_model.sv ----
/* Controller model: programs the selection and completes reads.
   Assumes one-cycle strobes on the system clock. */
`default_nettype none
module mcu_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] status_word_i,
  output logic sel_write_o,
  output logic [3:0] select_field_o,
  output logic select_persist_o,
  output logic read_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel_write_o = 1'b0;
    select_field_o = 4'h1;
    select_persist_o = 1'b0;
    read_done_o = 1'b0;
  end
  task automatic pick(input logic [3:0] code, input logic keep);
    @(posedge clk_sys_i);
    sel_write_o <= 1'b1;
    select_field_o <= code;
    select_persist_o <= keep;
    @(posedge clk_sys_i);
    sel_write_o <= 1'b0;
  endtask : pick
  task automatic fetch(output logic [15:0] word);
    repeat (3) @(posedge clk_sys_i);
    #1 word = status_word_i;
    @(posedge clk_sys_i);
    read_done_o <= 1'b1;
    @(posedge clk_sys_i);
    read_done_o <= 1'b0;
  endtask : fetch
endmodule : mcu_model
`default_nettype wire

// ---- tb/test_spi_fault_status_readout.sv ----
/* Bench for the status readback block.
   Assumes the controller model drives the selection and read strobes. */
`default_nettype none
module test_spi_fault_status_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, regs_reset_i = 1'b0, fail_mode_indicator_i = 1'b0;
  logic test_mode_i = 1'b0, overvoltage_i = 1'b0, undervoltage_i = 1'b0, serial_fail_i = 1'b0;
  logic charge_pump_i = 1'b0, clock_fail_i = 1'b0, limp_input_state_i = 1'b0;
  logic [4:0] overtemp_shutdown_i = 5'h00, overtemp_warning_i = 5'h00, oc_event_i = 5'h00;
  logic [4:0] open_load_on_state_i = 5'h00, open_load_off_state_i = 5'h00;
  logic [4:0] output_level_state_i = 5'h00;
  logic [14:0] overcurrent_cause_i = 15'h0000;
  logic [3:0] control_input_state_i = 4'h0, toggle_signal_i = 4'h0;
  logic sel_write_i, readback_select_persist_i, read_done_i;
  logic [3:0] readback_select_field_i, active_select_o;
  logic [15:0] status_word_o, word;
  int errors = 0;
  int comparisons = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  spi_fault_status_readout u_spi_fault_status_readout (.clk_sys_i, .rst_i, .sel_write_i,
    .readback_select_field_i, .readback_select_persist_i, .read_done_i, .regs_reset_i,
    .fail_mode_indicator_i, .overtemp_shutdown_i, .overtemp_warning_i, .oc_event_i,
    .overcurrent_cause_i, .open_load_on_state_i, .open_load_off_state_i, .test_mode_i,
    .overvoltage_i, .undervoltage_i, .serial_fail_i, .charge_pump_i, .clock_fail_i,
    .limp_input_state_i, .control_input_state_i, .toggle_signal_i, .output_level_state_i,
    .status_word_o, .active_select_o);
  mcu_model u_mcu_model (.clk_sys_i, .status_word_i(status_word_o), .sel_write_o(sel_write_i),
    .select_field_o(readback_select_field_i), .select_persist_o(readback_select_persist_i),
    .read_done_o(read_done_i));
  // Read one word and compare
  task automatic look(input string what, input logic [15:0] want);
    u_mcu_model.fetch(word);
    comparisons++;
    if (word !== want) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, want, word);
    end
  endtask : look
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i) {regs_reset_i, charge_pump_i, clock_fail_i} <= 3'h7;
    @(posedge clk_sys_i) {regs_reset_i, charge_pump_i, clock_fail_i} <= 3'h0;
    look("overview", 16'h14e0);
    look("overview", 16'h1000);
    @(posedge clk_sys_i) {oc_event_i, overtemp_shutdown_i} <= 10'h021;
    overcurrent_cause_i <= 15'h0005;
    @(posedge clk_sys_i) overcurrent_cause_i <= 15'h0006;
    overtemp_shutdown_i <= 5'h00;
    @(posedge clk_sys_i) overcurrent_cause_i <= 15'h0007;
    @(posedge clk_sys_i) oc_event_i <= 5'h00;
    u_mcu_model.pick(4'h2, 1'b0);
    look("channel", 16'h2258);
    look("overview", 16'h1000);
    look("overview", 16'h1000);
    @(posedge clk_sys_i) {test_mode_i, overvoltage_i, undervoltage_i, serial_fail_i} <= 4'hf;
    limp_input_state_i <= 1'b1;
    @(posedge clk_sys_i) {test_mode_i, overvoltage_i, undervoltage_i, serial_fail_i} <= 4'h0;
    u_mcu_model.pick(4'h7, 1'b1);
    look("device", 16'h741f);
    look("device", 16'h7001);
    @(posedge clk_sys_i) limp_input_state_i <= 1'b0;
    look("device", 16'h7000);
    @(posedge clk_sys_i) rst_i <= 1'b1;
    @(posedge clk_sys_i) rst_i <= 1'b0;
    look("overview", 16'h1440);
    @(posedge clk_sys_i) {fail_mode_indicator_i, control_input_state_i} <= 5'h1a;
    {toggle_signal_i, output_level_state_i} <= 9'h055;
    u_mcu_model.pick(4'h8, 1'b1);
    look("io", 16'h8b55);
    @(posedge clk_sys_i) fail_mode_indicator_i <= 1'b0;
    u_mcu_model.pick(4'h9, 1'b1);
    look("id", {8'h90, readout_pkg::PART_CODE});
    @(posedge clk_sys_i) undervoltage_i <= 1'b1;
    @(posedge clk_sys_i) undervoltage_i <= 1'b0;
    look("id", 16'h9000);
    u_mcu_model.pick(4'ha, 1'b0);
    look("unmapped", 16'h0000);
    u_mcu_model.pick(4'h0, 1'b0);
    look("alias", 16'h1400);
    @(posedge clk_sys_i) {overtemp_warning_i, open_load_off_state_i} <= 10'h3ff;
    @(posedge clk_sys_i) {overtemp_warning_i, open_load_off_state_i} <= 10'h000;
    look("overview", 16'h151f);
    for (int i = 0; i < 5; i++) begin
      u_mcu_model.pick(4'(i + 2), 1'b0);
      look("channel", 16'h2521 + (16'(i) << 12));
    end
    look("overview", 16'h1400);
    summarize();
  end
endmodule : test_spi_fault_status_readout
`default_nettype wire
